/* File: core_ctl.sv */
// Purpose : Register file, flags, stack pointer and interrupt vectoring
// Assumes : Inputs synchronous to mclk_in; instruction decode is outside
// Notes   : The core clock is mclk_in itself, never divided
`timescale 1ns/1ps
module core_ctl (
   // Clock and reset
   input  wire logic                        mclk_in,
   input  wire logic                        nrst_in,
   // Register file read ports
   input  wire logic [4:0]                  rd_a_addr_in,
   input  wire logic [4:0]                  rd_b_addr_in,
   output logic [7:0]                       rd_a_data_out,
   output logic [7:0]                       rd_b_data_out,
   output logic [15:0]                      rd_pair_data_out,
   // Register file write port
   input  wire core_ctl_pkg::rf_wr_t        rf_wr_in,
   // Result flags from the ALU
   input  wire logic                        alu_valid_in,
   input  wire logic [2:0]                  alu_flags_in,
   // Flags register access and global enable instructions
   input  wire logic                        flags_wr_in,
   input  wire logic [7:0]                  flags_wdata_in,
   input  wire logic                        gie_set_in,
   input  wire logic                        gie_clr_in,
   output logic [7:0]                       processor_flags_register_out,
   // Pointer access
   input  wire core_ctl_pkg::ptr_req_t      ptr_req_in,
   output logic [15:0]                      ptr_addr_out,
   // Data-space access to the register file
   input  wire logic                        ds_wr_in,
   input  wire logic [15:0]                 ds_addr_in,
   input  wire logic [7:0]                  ds_wdata_in,
   output logic                             ds_hit_out,
   output logic [7:0]                       ds_rdata_out,
   // I/O access for the stack pointer bytes
   input  wire logic                        io_wr_in,
   input  wire logic [5:0]                  io_addr_in,
   input  wire logic [7:0]                  io_wdata_in,
   output logic [7:0]                       io_rdata_out,
   // Stack operation and pointer
   input  wire core_ctl_pkg::sp_op_t        sp_op_in,
   output logic [15:0]                      stack_pointer_out,
   // Instruction boundary and program counter
   input  wire logic                        instr_done_in,
   input  wire logic                        interrupt_exit_in,
   input  wire logic                        sleeping_in,
   input  wire logic [15:0]                 pc_in,
   // Interrupt sources
   input  wire logic [core_ctl_pkg::NUM_SRC-1:0] irq_event_in,
   input  wire logic [core_ctl_pkg::NUM_SRC-1:0] irq_level_in,
   input  wire logic [core_ctl_pkg::NUM_SRC-1:0] irq_is_level_in,
   input  wire logic [core_ctl_pkg::NUM_SRC-1:0] irq_enable_in,
   input  wire logic                        flag_clr_wr_in,
   input  wire logic [core_ctl_pkg::NUM_SRC-1:0] flag_clr_data_in,
   output logic [core_ctl_pkg::NUM_SRC-1:0] irq_flags_out,
   // Vector control straps
   input  wire logic                        vector_table_relocate_in,
   input  wire logic                        boot_reset_vector_fuse_in,
   input  wire logic                        boot_lock_bit_a_in,
   input  wire logic                        boot_lock_bit_b_in,
   // Sequencer outputs and reset vector
   output logic                             irq_busy_out,
   output logic                             vector_valid_out,
   output logic [15:0]                      vector_addr_out,
   output logic [15:0]                      reset_vector_out
);
   localparam int N = core_ctl_pkg::NUM_SRC;

   logic [7:0]                      regs [32];
   logic [7:0]                      flags;
   logic [15:0]                     sp;
   logic [N-1:0]                    pend;
   core_ctl_pkg::seq_state_t        state;
   logic [2:0]                      cnt;
   logic                            hold_one;
   localparam int SRC_W = core_ctl_pkg::SRC_IDX_W;
   logic [SRC_W-1:0]                src;

   // Pointer pair selection
   wire logic [4:0]  ptr_lo   = (ptr_req_in.sel == 2'h0) ? core_ctl_pkg::PTR_X_LO :
                                (ptr_req_in.sel == 2'h1) ? core_ctl_pkg::PTR_Y_LO :
                                core_ctl_pkg::PTR_Z_LO;
   wire logic [15:0] ptr_base = {regs[ptr_lo + 5'h01], regs[ptr_lo]};
   wire logic [15:0] ptr_inc  = ptr_base + 16'h0001;
   wire logic [15:0] ptr_dec  = ptr_base - 16'h0001;
   wire logic        ptr_upd  = ptr_req_in.en && (ptr_req_in.mode != core_ctl_pkg::PM_DISP);
   wire logic [15:0] ptr_new  = (ptr_req_in.mode == core_ctl_pkg::PM_PRE) ? ptr_dec : ptr_inc;

   // Data-space hit on the register file window
   wire logic        ds_hit   = (ds_addr_in <= core_ctl_pkg::REGFILE_TOP);
   wire logic [4:0]  ds_idx   = ds_addr_in[4:0];

   // Combined flag and level requests, gated by enables
   wire logic        gie      = flags[core_ctl_pkg::FLAG_GIE];
   wire logic        boot_pc  = (pc_in >= core_ctl_pkg::BOOT_START);
   // Lock bit A: code outside the boot section may not be interrupted into it; lock bit B: boot code not out of it
   wire logic        lock_blk = (boot_lock_bit_a_in && !boot_pc && vector_table_relocate_in)
                              || (boot_lock_bit_b_in && boot_pc && !vector_table_relocate_in);
   wire logic [N-1:0] req_raw = (pend & ~irq_is_level_in) | (irq_level_in & irq_is_level_in);
   wire logic [N-1:0] req     = req_raw & irq_enable_in;
   wire logic        take     = (state == core_ctl_pkg::ST_RUN) && instr_done_in && gie && !gie_clr_in
                                && !hold_one && !lock_blk && (req != '0);

   // Fixed priority: lowest index is lowest vector address
   logic [SRC_W-1:0] win;
   always_comb begin
      win = '0;
      for (int i = N - 1; i >= 0; i--) begin
         if (req[i]) begin
            win = SRC_W'(i);
         end
      end
   end

   wire logic [15:0] vec_base = vector_table_relocate_in ? core_ctl_pkg::BOOT_START : 16'h0000;
   wire logic [15:0] vec_addr = vec_base + core_ctl_pkg::VEC_STEP * ({13'h0000, src} + 16'h0001);

   // Stack pointer next value
   wire logic [15:0] sp_step  = (sp_op_in == core_ctl_pkg::SP_PUSH1) ? 16'hFFFF :
                                (sp_op_in == core_ctl_pkg::SP_POP1)  ? 16'h0001 :
                                (sp_op_in == core_ctl_pkg::SP_CALL)  ? 16'hFFFE :
                                (sp_op_in == core_ctl_pkg::SP_RET)   ? 16'h0002 : 16'h0000;
   wire logic        entry_push = (state == core_ctl_pkg::ST_RUN) && take;
   wire logic        exit_pop   = (state == core_ctl_pkg::ST_RUN) && interrupt_exit_in;
   wire logic [15:0] sp_auto    = entry_push ? 16'hFFFE : exit_pop ? 16'h0002 : sp_step;
   wire logic [15:0] next_sp    = sp + sp_auto;

   // Register file: read ports are combinational so one cycle spans read, operate, write
   assign rd_a_data_out    = regs[rd_a_addr_in];
   assign rd_b_data_out    = regs[rd_b_addr_in];
   assign rd_pair_data_out = {regs[rd_a_addr_in | 5'h01], regs[rd_a_addr_in & 5'h1E]};
   assign ptr_addr_out     = (ptr_req_in.mode == core_ctl_pkg::PM_PRE)  ? ptr_dec :
                             (ptr_req_in.mode == core_ctl_pkg::PM_DISP) ? ptr_base + {10'h000, ptr_req_in.disp} :
                             ptr_base;
   assign ds_hit_out       = ds_hit;
   assign ds_rdata_out     = ds_hit ? regs[ds_idx] : 8'h00;
   assign io_rdata_out     = (io_addr_in == core_ctl_pkg::IO_SP_LOW)  ? sp[7:0] :
                             (io_addr_in == core_ctl_pkg::IO_SP_HIGH) ? sp[15:8] : 8'h00;
   assign stack_pointer_out            = sp;
   assign processor_flags_register_out = flags;
   assign irq_flags_out                = pend;
   assign irq_busy_out                 = (state != core_ctl_pkg::ST_RUN);
   assign reset_vector_out             = boot_reset_vector_fuse_in ? core_ctl_pkg::BOOT_START : 16'h0000;

   // Register file writes; pointer write-back and data-space writes share the array
   always_ff @(posedge mclk_in) begin
      if (rf_wr_in.en16) begin
         regs[rf_wr_in.addr & 5'h1E] <= rf_wr_in.data[7:0];
         regs[rf_wr_in.addr | 5'h01] <= rf_wr_in.data[15:8];
      end else if (rf_wr_in.en8) begin
         regs[rf_wr_in.addr] <= rf_wr_in.data[7:0];
      end
      if (ds_wr_in && ds_hit) begin
         regs[ds_idx] <= ds_wdata_in;
      end
      if (ptr_upd) begin
         regs[ptr_lo]          <= ptr_new[7:0];
         regs[ptr_lo + 5'h01]  <= ptr_new[15:8];
      end
   end

   // Flags register; no automatic save or restore around interrupts
   always_ff @(posedge mclk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         flags <= core_ctl_pkg::FLAGS_RESET;
      end else begin
         if (flags_wr_in) begin
            flags <= flags_wdata_in;
         end else if (alu_valid_in) begin
            flags[2:0] <= alu_flags_in;
         end
         if (gie_clr_in || entry_push) begin
            flags[core_ctl_pkg::FLAG_GIE] <= 1'b0;
         end else if (gie_set_in || (state == core_ctl_pkg::ST_EXIT && cnt == 3'h1)) begin
            flags[core_ctl_pkg::FLAG_GIE] <= 1'b1;
         end
      end
   end

   // Stack pointer; I/O write wins over the implicit adjust
   always_ff @(posedge mclk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         sp <= core_ctl_pkg::LAST_SRAM;
      end else if (io_wr_in && io_addr_in == core_ctl_pkg::IO_SP_LOW) begin
         sp[7:0] <= io_wdata_in;
      end else if (io_wr_in && io_addr_in == core_ctl_pkg::IO_SP_HIGH) begin
         sp[15:8] <= io_wdata_in;
      end else begin
         sp <= next_sp;
      end
   end

   // Sticky flags: a new event beats a clear in the same cycle
   generate
      for (genvar g = 0; g < N; g++) begin : g_flag
         wire logic hw_clr = entry_push && (win == SRC_W'(g)) && !irq_is_level_in[g];
         wire logic sw_clr = flag_clr_wr_in && flag_clr_data_in[g];
         always_ff @(posedge mclk_in or negedge nrst_in) begin
            if (!nrst_in) begin
               pend[g] <= 1'b0;
            end else if (irq_event_in[g]) begin
               pend[g] <= 1'b1;
            end else if (hw_clr || sw_clr) begin
               pend[g] <= 1'b0;
            end
         end
      end
   endgenerate

   // Sequencer: entry and exit each run four cycles, wake adds four
   always_ff @(posedge mclk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         state    <= core_ctl_pkg::ST_RUN;
         cnt      <= 3'h0;
         src      <= '0;
         hold_one <= 1'b0;
      end else begin
         case (state)
            core_ctl_pkg::ST_RUN: begin
               if (hold_one && instr_done_in) begin
                  hold_one <= 1'b0;
               end
               if (gie_set_in && !gie) begin
                  hold_one <= 1'b1;
               end
               if (take) begin
                  src   <= win;
                  cnt   <= core_ctl_pkg::ENTRY_CYC;
                  state <= sleeping_in ? core_ctl_pkg::ST_WAKE : core_ctl_pkg::ST_ENTRY;
               end else if (interrupt_exit_in) begin
                  cnt   <= core_ctl_pkg::EXIT_CYC;
                  state <= core_ctl_pkg::ST_EXIT;
               end
            end
            core_ctl_pkg::ST_WAKE: begin
               if (cnt == 3'h1) begin
                  cnt   <= core_ctl_pkg::WAKE_CYC;
                  state <= core_ctl_pkg::ST_ENTRY;
               end else begin
                  cnt <= cnt - 3'h1;
               end
            end
            core_ctl_pkg::ST_ENTRY: begin
               if (cnt == 3'h1) begin
                  state <= core_ctl_pkg::ST_RUN;
               end else begin
                  cnt <= cnt - 3'h1;
               end
            end
            core_ctl_pkg::ST_EXIT: begin
               if (cnt == 3'h1) begin
                  hold_one <= 1'b1;
                  state    <= core_ctl_pkg::ST_RUN;
               end else begin
                  cnt <= cnt - 3'h1;
               end
            end
            default: begin
               state <= core_ctl_pkg::ST_RUN;
            end
         endcase
      end
   end

   // Vector strobe registered, high the cycle after the last entry cycle
   always_ff @(posedge mclk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         vector_valid_out <= 1'b0;
         vector_addr_out  <= 16'h0000;
      end else begin
         vector_valid_out <= (state == core_ctl_pkg::ST_ENTRY) && (cnt == 3'h1);
         vector_addr_out  <= vec_addr;
      end
   end
endmodule

/* File: core_ctl_pkg.sv */
// Purpose : Constants and carrier types for the core control block
// Assumes : One 10 MHz clock, asynchronous active-low reset
// Notes   : Summary list of operation follows below
// Summary of operation
// - Flags N bit2, Z bit1, C bit0 from results
// - Four read/write port schemes, 8 and 16 bit
// - Registers mapped at data addresses 0x00-0x1F
// - Pairs 1A,1C,1E are pointers with inc/dec/disp
// - Stack grows down; byte push -1, pop +1
// - Calls and interrupt entry -2, returns +2
// - Stack pointer resets to last SRAM address
// - Stack pointer as I/O bytes 0x3E and 0x3D
// - Clock undivided; fetch overlaps execute
// - Read, operate, write back in one cycle
// - Serve only when both enables are one
// - Boot lock bits block interrupts by address
// - Vectors lowest; lower address higher priority
// - Relocate bit moves vectors to boot start
// - Boot reset fuse moves reset vector
// - Entry clears global enable; exit sets it
// - Hardware clears flag when vectoring
// - Writing one clears flag, zero keeps it
// - Disabled flags stay pending, served by priority
// - Level sources request only while present
// - One instruction after exit before next interrupt
// - Flags register not saved on entry or exit
// - Global disable takes effect immediately
// - One instruction after global enable first
// - Entry takes four cycles, pushing the PC
// - Exit takes four cycles, pops PC, sets enable
package core_ctl_pkg;
   localparam int          NUM_SRC      = 8;
   localparam int          SRC_IDX_W    = 3;
   localparam logic [4:0]  PTR_X_LO     = 5'h1A;
   localparam logic [4:0]  PTR_Y_LO     = 5'h1C;
   localparam logic [4:0]  PTR_Z_LO     = 5'h1E;
   localparam logic [15:0] REGFILE_TOP  = 16'h001F;
   localparam logic [5:0]  IO_SP_LOW    = 6'h3D;
   localparam logic [5:0]  IO_SP_HIGH   = 6'h3E;
   localparam logic [15:0] LAST_SRAM    = 16'h08FF;
   localparam logic [15:0] BOOT_START   = 16'h3800;
   localparam logic [15:0] VEC_STEP     = 16'h0002;
   localparam int          FLAG_GIE     = 7;
   localparam int          FLAG_N       = 2;
   localparam int          FLAG_Z       = 1;
   localparam int          FLAG_C       = 0;
   localparam logic [7:0]  FLAGS_RESET  = 8'h00;
   localparam logic [2:0]  ENTRY_CYC    = 3'h4;
   localparam logic [2:0]  EXIT_CYC     = 3'h4;
   localparam logic [2:0]  WAKE_CYC     = 3'h4;

   // Stack operations requested by instruction decode
   typedef enum logic [2:0] {
      SP_NONE  = 3'h0,
      SP_PUSH1 = 3'h1,
      SP_POP1  = 3'h2,
      SP_CALL  = 3'h3,
      SP_RET   = 3'h4
   } sp_op_t;

   // Pointer addressing modes
   typedef enum logic [1:0] {
      PM_DISP = 2'h0,
      PM_POST = 2'h1,
      PM_PRE  = 2'h2
   } ptr_mode_t;

   // Interrupt sequencer states, Gray along entry then exit
   typedef enum logic [2:0] {
      ST_RUN   = 3'b000,
      ST_ENTRY = 3'b001,
      ST_WAKE  = 3'b011,
      ST_EXIT  = 3'b010,
      ST_HOLD  = 3'b110
   } seq_state_t;

   // Register file write request
   typedef struct packed {
      logic       en8;
      logic       en16;
      logic [4:0] addr;
      logic [15:0] data;
   } rf_wr_t;

   // Pointer access request
   typedef struct packed {
      logic       en;
      logic [1:0] sel;
      ptr_mode_t  mode;
      logic [5:0] disp;
   } ptr_req_t;
endpackage

/* File: core_ctl_props.sv */
// Purpose : Port assertions for the core control block
// Assumes : One clock, asynchronous active-low reset
// Notes   : Bound from the testbench top file
`timescale 1ns/1ps
module core_ctl_props (
   // Inputs of the block
   input wire logic                 mclk_in,
   input wire logic                 nrst_in,
   input wire core_ctl_pkg::sp_op_t sp_op_in,
   input wire logic                 io_wr_in,
   input wire logic                 instr_done_in,
   input wire logic                 interrupt_exit_in,
   input wire logic                 sleeping_in,
   input wire logic                 gie_clr_in,
   input wire logic                 flags_wr_in,
   input wire logic                 flag_clr_wr_in,
   input wire logic [7:0]           flag_clr_data_in,
   input wire logic [7:0]           irq_event_in,
   // Outputs of the block
   input wire logic [15:0]          stack_pointer_out,
   input wire logic [7:0]           processor_flags_register_out,
   input wire logic [7:0]           irq_flags_out,
   input wire logic                 irq_busy_out,
   input wire logic                 vector_valid_out
);
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (!nrst_in);
   // Steps judged only when nothing else moves it
   wire quiet = !io_wr_in && !instr_done_in && !interrupt_exit_in && !irq_busy_out;
   // Entry: busy rises without an exit before it
   sequence s_entry;
      $rose(irq_busy_out) && !$past(interrupt_exit_in);
   endsequence
   sequence s_vector;
      !vector_valid_out ##1 vector_valid_out ##1 !vector_valid_out;
   endsequence
   a_push_step_down: assert property (
      quiet && sp_op_in == core_ctl_pkg::SP_PUSH1 |=> stack_pointer_out == $past(stack_pointer_out) - 16'h0001)
      else $error("push step wrong");
   a_pop_step_up: assert property (
      quiet && sp_op_in == core_ctl_pkg::SP_POP1 |=> stack_pointer_out == $past(stack_pointer_out) + 16'h0001)
      else $error("pop step wrong");
   a_call_step_two: assert property (
      quiet && sp_op_in == core_ctl_pkg::SP_CALL |=> stack_pointer_out == $past(stack_pointer_out) - 16'h0002)
      else $error("call step wrong");
   a_take_needs_enable: assert property (
      s_entry |-> $past(processor_flags_register_out[7]) && !$past(gie_clr_in))
      else $error("take without enable");
   a_entry_clears_enable: assert property (
      s_entry |-> !processor_flags_register_out[7])
      else $error("enable kept on entry");
   a_vector_in_four: assert property (
      s_entry ##0 !$past(sleeping_in) |-> ##[2:3] s_vector)
      else $error("vector pulse late");
   a_clear_stops_take: assert property (
      gie_clr_in && !flags_wr_in |=> !processor_flags_register_out[7])
      else $error("disable not at once");
   a_write_one_clears: assert property (
      flag_clr_wr_in |=> (irq_flags_out & $past(flag_clr_data_in) & ~$past(irq_event_in)) == 8'h00)
      else $error("flag not cleared");
endmodule

/* File: core_ctl_test.sv */
// Purpose : Self-checking bench for the core control block
// Assumes : Partner model supplies events and instruction boundaries
// Notes   : Lock straps and PC stay low; every wait is bounded
`timescale 1ns/1ps
module core_ctl_test;
   // Design inputs and outputs, named as the ports
   logic                   mclk_in = 1'b0;
   logic                   nrst_in, alu_valid_in, flags_wr_in, gie_set_in, gie_clr_in, ds_wr_in, io_wr_in;
   logic                   interrupt_exit_in, sleeping_in, flag_clr_wr_in, vector_table_relocate_in, run;
   logic                   boot_reset_vector_fuse_in, boot_lock_bit_a_in, boot_lock_bit_b_in, instr_done_in;
   logic                   ds_hit_out, irq_busy_out, vector_valid_out;
   logic [2:0]             alu_flags_in;
   logic [4:0]             rd_a_addr_in, rd_b_addr_in;
   logic [5:0]             io_addr_in;
   logic [7:0]             io_wdata_in, ds_wdata_in, flags_wdata_in, flag_clr_data_in, fire, irq_event_in;
   logic [7:0]             irq_level_in, irq_is_level_in, irq_enable_in, irq_flags_out, rd_a_data_out;
   logic [7:0]             rd_b_data_out, ds_rdata_out, io_rdata_out, processor_flags_register_out;
   logic [15:0]            ds_addr_in, pc_in, exp_sp, rd_pair_data_out, ptr_addr_out, stack_pointer_out;
   logic [15:0]            vector_addr_out, reset_vector_out;
   core_ctl_pkg::rf_wr_t   rf_wr_in;
   core_ctl_pkg::ptr_req_t ptr_req_in;
   core_ctl_pkg::sp_op_t   sp_op_in;
   int                     n_mismatch = 0;
   int                     cmp_count = 0;
   typedef struct packed {
      core_ctl_pkg::sp_op_t op;
      logic [15:0]          delta;
   } sp_row_t;
   // Each stack operation beside the step it must make
   sp_row_t rows[5] = '{'{core_ctl_pkg::SP_PUSH1, 16'hFFFF}, '{core_ctl_pkg::SP_CALL, 16'hFFFE},
      '{core_ctl_pkg::SP_POP1, 16'h0001}, '{core_ctl_pkg::SP_RET, 16'h0002}, '{core_ctl_pkg::SP_NONE, 16'h0000}};

   core_ctl u_dut (.*);
   irq_partner u_src (.mclk_in(mclk_in), .nrst_in(nrst_in), .fire_in(fire), .run_in(run),
                      .irq_event_out(irq_event_in), .instr_done_out(instr_done_in));
   // Core clock, 100 ns period
   always #50 mclk_in = ~mclk_in;

   task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
      cmp_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic final_report;
      if (n_mismatch == 0 && cmp_count > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task automatic edges(input int n);
      repeat (n) @(posedge mclk_in);
   endtask
   // A missing vector is a mismatch and ends the run
   task automatic wait_vector;
      for (int i = 0; i < 20 && vector_valid_out !== 1'b1; i++) begin
         edges(1);
         #1;
      end
      if (vector_valid_out !== 1'b1) begin
         n_mismatch++;
         final_report;
      end
   endtask
   task automatic io_write(input logic [5:0] a, input logic [7:0] d);
      edges(1);
      {io_wr_in, io_addr_in, io_wdata_in} <= {1'b1, a, d};
      edges(1);
      io_wr_in <= 1'b0;
   endtask
   task automatic fire_evt(input logic [7:0] bits);
      edges(1);
      fire <= bits;
      edges(1);
      fire <= 8'h00;
   endtask
   task automatic exit_irq;
      edges(1);
      interrupt_exit_in <= 1'b1;
      edges(1);
      interrupt_exit_in <= 1'b0;
      edges(5);
      #1;
   endtask

   // Reset, table of stack steps, then hand-written cases
   initial begin
      {nrst_in, alu_valid_in, flags_wr_in, gie_set_in, gie_clr_in, ds_wr_in, io_wr_in, interrupt_exit_in,
       sleeping_in, flag_clr_wr_in, vector_table_relocate_in, run, boot_reset_vector_fuse_in, boot_lock_bit_a_in,
       boot_lock_bit_b_in, alu_flags_in, rd_a_addr_in, rd_b_addr_in, io_addr_in, io_wdata_in, ds_wdata_in,
       flags_wdata_in, flag_clr_data_in, fire, irq_level_in, irq_is_level_in, irq_enable_in, ds_addr_in,
       pc_in, rf_wr_in, ptr_req_in} = '0;
      sp_op_in = core_ctl_pkg::SP_NONE;
      edges(8);
      nrst_in <= 1'b1;
      #1;
      check("stack_pointer", core_ctl_pkg::LAST_SRAM, stack_pointer_out);
      check("flags", 16'h0000, 16'(processor_flags_register_out));
      check("io_unmapped", 16'h0000, 16'(io_rdata_out));
      check("reset_vector", 16'h0000, reset_vector_out);
      exp_sp = core_ctl_pkg::LAST_SRAM;
      foreach (rows[k]) begin
         edges(1);
         sp_op_in <= rows[k].op;
         edges(1);
         sp_op_in <= core_ctl_pkg::SP_NONE;
         #1;
         exp_sp = exp_sp + rows[k].delta;
         check("stack_pointer", exp_sp, stack_pointer_out);
      end
      // Software places the stack first
      io_write(6'h3E, 8'h01);
      io_write(6'h3D, 8'h23);
      #1;
      check("stack_pointer", 16'h0123, stack_pointer_out);
      check("io_sp_low", 16'h0023, 16'(io_rdata_out));
      // Pair write, byte write, data-space write and pointer modes
      edges(1);
      rf_wr_in <= '{en8: 1'b0, en16: 1'b1, addr: 5'h1E, data: 16'h1234};
      rd_a_addr_in <= 5'h1E;
      rd_b_addr_in <= 5'h05;
      ds_addr_in <= 16'h001F;
      edges(1);
      rf_wr_in <= '{en8: 1'b1, en16: 1'b0, addr: 5'h05, data: 16'h00A5};
      #1;
      check("pair_read", 16'h1234, rd_pair_data_out);
      check("ds_read", 16'h0012, 16'(ds_rdata_out));
      check("ds_hit", 16'h0001, 16'(ds_hit_out));
      check("rd_a", 16'h0034, 16'(rd_a_data_out));
      edges(1);
      rf_wr_in <= '0;
      ptr_req_in <= '{en: 1'b1, sel: 2'h2, mode: core_ctl_pkg::PM_POST, disp: 6'h00};
      {ds_wr_in, ds_addr_in, ds_wdata_in} <= {1'b1, 16'h0005, 8'h5A};
      #1;
      check("byte_read", 16'h00A5, 16'(rd_b_data_out));
      check("ptr_post", 16'h1234, ptr_addr_out);
      edges(1);
      ptr_req_in <= '{en: 1'b1, sel: 2'h2, mode: core_ctl_pkg::PM_DISP, disp: 6'h3F};
      ds_wr_in <= 1'b0;
      #1;
      check("ds_write", 16'h005A, 16'(rd_b_data_out));
      check("ptr_disp", 16'h1274, ptr_addr_out);
      edges(1);
      ptr_req_in <= '{en: 1'b1, sel: 2'h2, mode: core_ctl_pkg::PM_PRE, disp: 6'h00};
      #1;
      check("ptr_pre", 16'h1234, ptr_addr_out);
      edges(1);
      ptr_req_in <= '0;
      alu_valid_in <= 1'b1;
      alu_flags_in <= 3'b101;
      edges(1);
      alu_valid_in <= 1'b0;
      #1;
      check("pair_after_pre", 16'h1234, rd_pair_data_out);
      check("flags", 16'h0005, 16'(processor_flags_register_out));
      edges(1);
      {flags_wr_in, flags_wdata_in} <= {1'b1, 8'h85};
      edges(1);
      flags_wr_in <= 1'b0;
      // Event while its own enable is off must wait
      fire_evt(8'h08);
      run <= 1'b1;
      edges(6);
      #1;
      check("busy", 16'h0000, 16'(irq_busy_out));
      check("pending", 16'h0008, 16'(irq_flags_out));
      edges(1);
      irq_enable_in <= 8'h08;
      wait_vector;
      check("vector", 16'h0008, vector_addr_out);
      check("flags", 16'h0005, 16'(processor_flags_register_out));
      check("pending", 16'h0000, 16'(irq_flags_out));
      check("stack_pointer", 16'h0121, stack_pointer_out);
      edges(1);
      run <= 1'b0;
      exit_irq;
      check("flags", 16'h0085, 16'(processor_flags_register_out));
      check("stack_pointer", 16'h0123, stack_pointer_out);
      // Two pending sources, table at the boot start
      edges(1);
      vector_table_relocate_in <= 1'b1;
      irq_enable_in <= 8'h22;
      fire_evt(8'h22);
      run <= 1'b1;
      wait_vector;
      check("vector", 16'h3804, vector_addr_out);
      check("pending", 16'h0020, 16'(irq_flags_out));
      edges(1);
      {run, vector_table_relocate_in} <= 2'b00;
      exit_irq;
      // Disable landing on the same boundary as a pending request
      edges(1);
      run <= 1'b1;
      edges(2);
      gie_clr_in <= 1'b1;
      edges(1);
      gie_clr_in <= 1'b0;
      edges(6);
      #1;
      check("busy", 16'h0000, 16'(irq_busy_out));
      check("flags", 16'h0005, 16'(processor_flags_register_out));
      edges(1);
      run <= 1'b0;
      fire_evt(8'h04);
      edges(1);
      {flag_clr_wr_in, flag_clr_data_in} <= {1'b1, 8'h20};
      edges(1);
      flag_clr_wr_in <= 1'b0;
      #1;
      check("pending", 16'h0004, 16'(irq_flags_out));
      // Level source gone before enabling, then one that stays, from sleep
      edges(1);
      {irq_enable_in, irq_is_level_in, irq_level_in} <= {8'h40, 8'h40, 8'h40};
      edges(1);
      {irq_level_in, gie_set_in} <= {8'h00, 1'b1};
      edges(1);
      {gie_set_in, run} <= 2'b01;
      edges(6);
      #1;
      check("busy", 16'h0000, 16'(irq_busy_out));
      edges(1);
      {irq_level_in, sleeping_in} <= {8'h40, 1'b1};
      wait_vector;
      check("vector", 16'h000E, vector_addr_out);
      edges(1);
      {run, sleeping_in, irq_level_in, boot_reset_vector_fuse_in} <= {2'b00, 8'h00, 1'b1};
      #1;
      check("reset_vector", core_ctl_pkg::BOOT_START, reset_vector_out);
      final_report;
   end
endmodule

bind core_ctl core_ctl_props u_props (.*);

/* File: irq_partner.sv */
// Purpose : Stand-in for interrupt sources and the instruction stream
// Assumes : Commanded by the bench on the core clock
// Notes   : Boundary every other running cycle
`timescale 1ns/1ps
module irq_partner (
   // Clock and reset
   input  wire logic       mclk_in,
   input  wire logic       nrst_in,
   // Bench commands
   input  wire logic [7:0] fire_in,
   input  wire logic       run_in,
   // Toward the core
   output logic [7:0]      irq_event_out,
   output logic            instr_done_out
);
   logic phase;
   // Fetch overlaps execution, so no idle cycle before the first boundary
   assign instr_done_out = run_in && phase;
   // One-cycle events; the core latches them
   always_ff @(posedge mclk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         phase <= 1'b1;
         irq_event_out <= 8'h00;
      end else begin
         phase <= run_in ? !phase : 1'b1;
         irq_event_out <= fire_in;
      end
   end
endmodule
